/* logic/flash_bus_host.sv */
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"

module flash_bus_host
  import flash_host_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output flash_pins_type pins,
  input wire logic [15:0] data_lines_in,
  output logic [15:0] data_lines_out,
  output logic [15:0] data_lines_oe,
  input wire logic ready_busy_n
);
  // Bus slave state
  logic awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  // Software registers
  op_type op_ff, nxt_op;
  logic byte_mode_ff, nxt_byte_mode, temp_unprot_ff, nxt_temp_unprot;
  logic [19:0] addr_ff, nxt_addr;
  logic [15:0] wdata_ff, nxt_wdata, rd_ff, nxt_rd;
  logic done_ff, nxt_done;
  // Pin sequencer
  state_type state_ff, nxt_state;
  logic [7:0] cnt_ff, nxt_cnt;
  flash_pins_type pins_ff, nxt_pins;
  logic [15:0] dout_ff, nxt_dout, doe_ff, nxt_doe;
  logic start;
  logic [31:0] wmask, wval, regval;

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign pins = pins_ff;
  assign data_lines_out = dout_ff;
  assign data_lines_oe = doe_ff;

  // Next values of bus slave, registers and pin sequencer
  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_have = w_have_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_op = op_ff;
    nxt_byte_mode = byte_mode_ff;
    nxt_temp_unprot = temp_unprot_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rd = rd_ff;
    nxt_done = done_ff;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_pins = pins_ff;
    nxt_dout = dout_ff;
    nxt_doe = doe_ff;
    start = 1'b0;
    wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
    wval = w_data_ff & wmask;
    regval = 32'h0000_0000;

    // Capture write address and data in either order
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_have = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_have = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end

    // Register write; a command while busy is dropped
    if (aw_have_ff && w_have_ff && !bvalid_ff) begin
      nxt_aw_have = 1'b0;
      nxt_w_have = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `RESP_OKAY;
      case (aw_addr_ff)
        `REG_CMD: begin
          if (w_strb_ff[0] && state_ff == ST_IDLE) begin
            nxt_op = op_type'(w_data_ff[2:0]);
            start = 1'b1;
          end
        end
        `REG_CFG: begin
          if (w_strb_ff[0]) begin
            nxt_byte_mode = w_data_ff[`CFG_BYTE_BIT];
            nxt_temp_unprot = w_data_ff[`CFG_TEMP_UNPROT_BIT];
          end
        end
        `REG_ADDR: nxt_addr = (addr_ff & ~wmask[19:0]) | wval[19:0];
        `REG_WDATA: nxt_wdata = (wdata_ff & ~wmask[15:0]) | wval[15:0];
        `REG_STATUS: begin
          if (wval[`ST_DONE_BIT]) begin
            nxt_done = 1'b0;
          end
        end
        `REG_RDATA: ;
        default: nxt_bresp = `RESP_SLVERR;
      endcase
    end

    // Register read, one word per address
    if (s_axi_arvalid && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = `RESP_OKAY;
      case (s_axi_araddr)
        `REG_CMD: regval[2:0] = op_ff;
        `REG_CFG: regval[1:0] = {temp_unprot_ff, byte_mode_ff};
        `REG_ADDR: regval[19:0] = addr_ff;
        `REG_WDATA: regval[15:0] = wdata_ff;
        `REG_RDATA: regval[15:0] = rd_ff;
        `REG_STATUS: begin
          regval[`ST_BUSY_BIT] = state_ff != ST_IDLE;
          regval[`ST_DONE_BIT] = done_ff;
          regval[`ST_RYBY_BIT] = ready_busy_n;
        end
        default: nxt_rresp = `RESP_SLVERR;
      endcase
      nxt_rdata = regval;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end else if (!rvalid_ff) begin
      nxt_arready = 1'b1;
    end

    // Idle levels: select and reset high is standby; width pin follows config
    nxt_pins.byte_n = byte_mode_ff ? 1'b0 : 1'b1;
    // In byte mode the top data line carries the extra address bit
    nxt_doe[15] = byte_mode_ff | (doe_ff[15] & state_ff != ST_IDLE);
    if (byte_mode_ff) begin
      nxt_dout[15] = addr_ff[`ADDR_LSB_BIT];
    end

    case (state_ff)
      ST_IDLE: begin
        nxt_pins.chip_sel_n = 1'b1;
        nxt_pins.out_en_n = 1'b1;
        nxt_pins.wr_en_n = 1'b1;
        nxt_pins.reset_n = 1'b1;
        // Held elevated reset lets commands alter locked sectors
        nxt_pins.elevated_voltage_level = temp_unprot_ff;
        nxt_doe[14:0] = 15'h0000;
        if (start) begin
          nxt_state = ST_SETUP;
          nxt_pins.addr = addr_ff[18:0];
          nxt_cnt = 8'h01;
        end
      end
      ST_SETUP: begin
        // Address settles before any strobe falls, except bits 6 and 1:0, which protect ops set here with the strobe
        nxt_state = ST_ACTIVE;
        case (op_ff)
          OP_READ: begin
            nxt_pins.chip_sel_n = 1'b0;
            nxt_pins.out_en_n = 1'b0;
            nxt_cnt = `T_CE_CYC;
          end
          OP_WRITE: begin
            nxt_pins.chip_sel_n = 1'b0;
            nxt_pins.wr_en_n = 1'b0;
            nxt_dout[14:0] = wdata_ff[14:0];
            nxt_doe[14:8] = byte_mode_ff ? 7'h00 : 7'h7f;
            nxt_doe[7:0] = 8'hff;
            if (!byte_mode_ff) begin
              nxt_dout[15] = wdata_ff[15];
              nxt_doe[15] = 1'b1;
            end
            nxt_cnt = `T_WP_CYC;
          end
          OP_PROTECT, OP_UNPROTECT: begin
            nxt_pins.elevated_voltage_level = 1'b1;
            nxt_pins.chip_sel_n = 1'b0;
            nxt_pins.wr_en_n = 1'b0;
            nxt_pins.addr[`PROT_SEL_BIT] = op_ff == OP_UNPROTECT;
            nxt_pins.addr[1:0] = 2'b10;
            nxt_cnt = `T_PP_CYC;
          end
          default: begin
            // Reset pulse: outputs released while low
            nxt_pins.reset_n = 1'b0;
            nxt_pins.elevated_voltage_level = 1'b0;
            nxt_doe[14:0] = 15'h0000;
            nxt_cnt = `T_RB_CYC;
          end
        endcase
      end
      ST_ACTIVE: begin
        if (cnt_ff > 8'h01) begin
          nxt_cnt = cnt_ff - 8'h01;
        end else begin
          nxt_state = ST_RECOVER;
          nxt_cnt = `T_RH_CYC;
          nxt_pins.out_en_n = 1'b1;
          nxt_pins.wr_en_n = 1'b1;
          nxt_pins.reset_n = 1'b1;
          if (op_ff == OP_READ) begin
            // Byte mode keeps only the low byte; status and ids also sit there
            nxt_rd = byte_mode_ff ? {8'h00, data_lines_in[7:0]} : data_lines_in;
          end
        end
      end
      ST_RECOVER: begin
        // Data held one cycle past the strobe; reset also waits recovery time
        nxt_doe[14:0] = 15'h0000;
        nxt_pins.chip_sel_n = 1'b1;
        nxt_pins.elevated_voltage_level = temp_unprot_ff;
        if (op_ff != OP_RESET || cnt_ff <= 8'h01) begin
          nxt_state = ST_IDLE;
          nxt_done = 1'b1;
        end else begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase

    nxt_awready = !nxt_aw_have && !nxt_bvalid;
    nxt_wready = !nxt_w_have && !nxt_bvalid;
  end

  // Registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
      op_ff <= OP_READ;
      byte_mode_ff <= 1'b0;
      temp_unprot_ff <= 1'b0;
      addr_ff <= 20'h00000;
      wdata_ff <= 16'h0000;
      rd_ff <= 16'h0000;
      done_ff <= 1'b0;
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      pins_ff <= '{addr: 19'h00000, chip_sel_n: 1'b1, out_en_n: 1'b1, wr_en_n: 1'b1,
                   reset_n: 1'b1, elevated_voltage_level: 1'b0, byte_n: 1'b1};
      dout_ff <= 16'h0000;
      doe_ff <= 16'h0000;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      op_ff <= nxt_op;
      byte_mode_ff <= nxt_byte_mode;
      temp_unprot_ff <= nxt_temp_unprot;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rd_ff <= nxt_rd;
      done_ff <= nxt_done;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      pins_ff <= nxt_pins;
      dout_ff <= nxt_dout;
      doe_ff <= nxt_doe;
    end
  end
endmodule
`default_nettype wire

/* logic/flash_host_map.svh */
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

`define CLK_NS 10
`define T_CE_NS 150
`define T_WP_NS 50
`define T_PP_NS 1000
`define T_RB_NS 500
`define T_RH_NS 50
`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define T_CE_CYC 8'(`CYC_UP(`T_CE_NS))
`define T_WP_CYC 8'(`CYC_UP(`T_WP_NS))
`define T_PP_CYC 8'(`CYC_UP(`T_PP_NS))
`define T_RB_CYC 8'(`CYC_UP(`T_RB_NS))
`define T_RH_CYC 8'(`CYC_UP(`T_RH_NS))

`define REG_CMD 8'h00
`define REG_CFG 8'h04
`define REG_ADDR 8'h08
`define REG_WDATA 8'h0c
`define REG_RDATA 8'h10
`define REG_STATUS 8'h14

`define CFG_BYTE_BIT 0
`define CFG_TEMP_UNPROT_BIT 1
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_RYBY_BIT 2
`define ADDR_LSB_BIT 19
`define PROT_SEL_BIT 6

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* logic/flash_host_pkg.sv */
package flash_host_pkg;
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_WRITE = 3'h1,
    OP_PROTECT = 3'h2,
    OP_UNPROTECT = 3'h3,
    OP_RESET = 3'h4
  } op_type;

  // Gray coded along idle, setup, active, recover
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_ACTIVE = 2'b11,
    ST_RECOVER = 2'b10
  } state_type;

  typedef struct packed {
    logic [18:0] addr;
    logic chip_sel_n;
    logic out_en_n;
    logic wr_en_n;
    logic reset_n;
    logic elevated_voltage_level;
    logic byte_n;
  } flash_pins_type;
endpackage

/* tb/flash_bus_host_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_bus_host_checker
  import flash_host_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire flash_pins_type pins,
  input wire logic [15:0] data_lines_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [7:0] low_cnt_ff;
  logic [7:0] nxt_low_cnt;
  // Length of the open read strobe; a read never outlasts the counter's range
  always_comb begin
    nxt_low_cnt = pins.out_en_n ? 8'h00 : low_cnt_ff + 8'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) low_cnt_ff <= 8'h00;
    else low_cnt_ff <= nxt_low_cnt;
  end
  // Strobe levels, width handling and pulse lengths
  AST_READ_LEVELS: assert property (!pins.out_en_n |->
    !pins.chip_sel_n && pins.wr_en_n && pins.reset_n) else $error("bad read levels");
  AST_WRITE_LEVELS: assert property (!pins.wr_en_n |->
    !pins.chip_sel_n && pins.out_en_n) else $error("bad write levels");
  AST_NO_CONTENTION: assert property ((|data_lines_oe[14:0] ||
    (pins.byte_n && data_lines_oe[15])) |-> pins.out_en_n)
    else $error("host drives data while device outputs");
  AST_STANDBY_RELEASED: assert property (pins.chip_sel_n |-> data_lines_oe[14:0] == 15'h0000)
    else $error("data lines driven while deselected");
  AST_BYTE_UPPER: assert property (!pins.byte_n |-> data_lines_oe[14:8] == 7'h00)
    else $error("upper lines driven in byte mode");
  AST_BYTE_LSB: assert property (!pins.byte_n && !pins.chip_sel_n |-> data_lines_oe[15])
    else $error("extra address bit not driven");
  AST_READ_ACCESS: assert property ($rose(pins.out_en_n) |-> low_cnt_ff >= 8'h0f)
    else $error("read strobe too short");
  AST_PROTECT_ADDR: assert property (!pins.wr_en_n [*8] |->
    pins.elevated_voltage_level && pins.addr[1:0] == 2'h2) else $error("bad protect pulse");
  AST_RESET_PULSE: assert property ($fell(pins.reset_n) |=> !pins.reset_n [*8])
    else $error("reset pulse too short");
  AST_ADDR_STABLE: assert property (!pins.chip_sel_n && !$past(pins.chip_sel_n) |->
    $stable(pins.addr)) else $error("address moved during access");
endmodule
bind flash_bus_host flash_bus_host_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .pins(pins), .data_lines_oe(data_lines_oe));
`default_nettype wire

/* tb/flash_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model
  import flash_host_pkg::*;
(
  input wire logic aclk,
  input wire flash_pins_type pins,
  input wire logic [15:0] host_out,
  input wire logic [15:0] host_oe,
  output logic [15:0] wire_dq,
  output logic ready_busy_n
);
  logic [15:0] mem [256]; // Flat array; erase sequences are plain command writes
  logic [15:0] float_ff = 16'h5a5a;
  logic [15:0] dev_out;
  logic [15:0] dev_oe;
  logic [6:0] prot_addr;
  logic wr_act;
  time t_wr = 0;
  time t_rst = 0;
  time rst_len = 0;
  // Known pattern from power-up, so array reads need no command
  initial for (int i = 0; i < 256; i++) mem[i] = 16'ha500 | 16'(i);
  // Released lines change every cycle so a stale value is never mistaken for data
  always @(posedge aclk) float_ff <= ~float_ff;
  // Drive only on a read with reset released or elevated voltage level; otherwise released lines carry the toggling float_ff pattern
  always_comb begin
    dev_out = mem[pins.addr[7:0]];
    if (!pins.byte_n) dev_out = {8'h00, wire_dq[15] ? dev_out[15:8] : dev_out[7:0]};
    dev_oe = 16'h0000;
    if (!pins.chip_sel_n && !pins.out_en_n && pins.wr_en_n &&
        (pins.reset_n || pins.elevated_voltage_level))
      dev_oe = pins.byte_n ? 16'hffff : 16'h00ff;
  end
  assign wire_dq = (host_oe & host_out) | (~host_oe & dev_oe & dev_out) |
    (~host_oe & ~dev_oe & float_ff);
  // Latches capture when select or write strobe ends, whichever is first
  assign wr_act = !pins.chip_sel_n && !pins.wr_en_n;
  always @(negedge wr_act) begin
    if (pins.elevated_voltage_level) prot_addr <= pins.addr[6:0];
    else if (pins.reset_n) begin
      mem[pins.addr[7:0]] <= wire_dq;
      t_wr <= $time;
    end
  end
  // Busy for a while after a program, whatever the select does
  always @(posedge aclk) ready_busy_n <= ($time - t_wr) >= 400;
  // Reset pulse returns to array reads; its length is kept for the bench
  always @(negedge pins.reset_n) t_rst = $time;
  always @(posedge pins.reset_n) rst_len = $time - t_rst;
endmodule
`default_nettype wire

/* tb/test_flash_bus_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_map.svh"
module test_flash_bus_host
  import flash_host_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, ready_busy_n;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] data_lines_in, data_lines_out, data_lines_oe;
  flash_pins_type pins;
  int miscompares = 0;
  int cmp_count = 0;
  flash_bus_host u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins, .data_lines_in, .data_lines_out,
    .data_lines_oe, .ready_busy_n);
  flash_dev_model u_flash (.aclk, .pins, .host_out(data_lines_out), .host_oe(data_lines_oe),
    .wire_dq(data_lines_in), .ready_busy_n);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    // Ready stays high: a release here would be raised again in the same step by the next call
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Start an operation and poll until the sequencer is idle again
  task automatic run(input logic [2:0] c);
    logic [31:0] s;
    wr(`REG_CMD, {29'h0, c}, `RESP_OKAY);
    do rd(`REG_STATUS, s, `RESP_OKAY); while (s[0] !== 1'b0);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Cut a hang short; the sequence needs well under 2000 cycles
  initial begin
    #50000;
    miscompares++;
    end_of_test();
  end
  initial begin
    logic [31:0] v;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({28'h0, pins.chip_sel_n, pins.out_en_n, pins.wr_en_n, pins.reset_n}, 32'hf);
    wr(`REG_ADDR, 32'h123, `RESP_OKAY);
    run(3'h0);
    rd(`REG_RDATA, v, `RESP_OKAY);
    chk(v, 32'ha523);
    rd(`REG_STATUS, v, `RESP_OKAY);
    chk(v & 32'h2, 32'h2);
    wr(`REG_STATUS, 32'h2, `RESP_OKAY);
    rd(`REG_STATUS, v, `RESP_OKAY);
    chk(v & 32'h2, 32'h0);
    // A command written while the read runs is dropped
    wr(`REG_CMD, 32'h0, `RESP_OKAY);
    run(3'h4);
    rd(`REG_CMD, v, `RESP_OKAY);
    chk(v, 32'h0);
    // Only the strobed byte of the address changes
    s_axi_wstrb <= 4'h1;
    wr(`REG_ADDR, 32'hffff_ff23, `RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(`REG_ADDR, v, `RESP_OKAY);
    chk(v, 32'h123);
    wr(`REG_CFG, 32'h2, `RESP_OKAY);
    @(posedge aclk);
    chk({31'h0, pins.elevated_voltage_level}, 32'h1);
    wr(`REG_CFG, 32'h0, `RESP_OKAY);
    wr(`REG_WDATA, 32'h1234, `RESP_OKAY);
    run(3'h1);
    run(3'h1);
    rd(`REG_STATUS, v, `RESP_OKAY);
    chk(v & 32'h4, 32'h0);
    run(3'h0);
    rd(`REG_RDATA, v, `RESP_OKAY);
    chk(v, 32'h1234);
    repeat (40) @(posedge aclk);
    rd(`REG_STATUS, v, `RESP_OKAY);
    chk(v & 32'h4, 32'h4);
    wr(`REG_CFG, 32'h1, `RESP_OKAY);
    wr(`REG_ADDR, 32'h80023, `RESP_OKAY);
    run(3'h0);
    rd(`REG_RDATA, v, `RESP_OKAY);
    chk(v, 32'h12);
    wr(`REG_CFG, 32'h0, `RESP_OKAY);
    wr(`REG_ADDR, 32'h7ffff, `RESP_OKAY);
    run(3'h2);
    chk({25'h0, u_flash.prot_addr}, 32'h3e);
    run(3'h3);
    chk({25'h0, u_flash.prot_addr}, 32'h7e);
    run(3'h4);
    chk(32'(u_flash.rst_len), 32'h1f4);
    run(3'h0);
    rd(`REG_RDATA, v, `RESP_OKAY);
    chk(v, 32'ha5ff);
    wr(8'h40, 32'h1, `RESP_SLVERR);
    rd(8'h40, v, `RESP_SLVERR);
    chk(v, 32'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
